/* File: hw/dsc_sync.sv */
// Two-flop synchronizer for every asynchronous pin input
`timescale 1ns/10ps
module dsc_sync #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Raw pins in, synchronized levels out
  input  wire logic [WIDTH-1:0] pinsAsync,
  output logic      [WIDTH-1:0] pinsSync
);

  logic [WIDTH-1:0] stage1_r;  // First stage, read only by second stage

  ////////////////////////////////////////////////////////////////////
  // Two flops; idle level high since all inputs are active low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1_r <= {WIDTH{1'b1}};
      pinsSync <= {WIDTH{1'b1}};
    end else begin
      stage1_r <= pinsAsync;
      pinsSync <= stage1_r;
    end
  end

endmodule

/* File: hw/dsc_sys_ctrl.sv */
// Top of the DSP system control pin block
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module dsc_sys_ctrl
  import dsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Interrupt and control pins
  input  wire logic [3:0]  userIrqIn_b,
  input  wire logic        nmiIn_b,
  input  wire logic        branchCondIn_b,
  input  wire logic        holdReq_b,
  input  wire logic        offCtrl_b,
  input  wire logic        romMapStrap,
  // Core-side bus request
  input  wire logic        accReq,
  input  wire dsc_space_e  accSpace,
  input  wire logic [15:0] accAddr,
  input  wire logic        xcDecode,
  input  wire logic        branchExec,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // Core-side results
  output logic      [15:0] fetchAddr,
  output logic             fetchValid,
  output logic             computerMode,
  output logic             branchTaken,
  output logic             xcCondTrue,
  output logic             coreHalted,
  // Pins out, each with output enable
  output logic      [15:0] addrOut,
  output logic             addrOe,
  output logic             extFlagOut,
  output logic             extFlagOe,
  output logic             dataSpaceSel_b,
  output logic             progSpaceSel_b,
  output logic             ioSpaceSel_b,
  output logic             spaceSelOe,
  output logic             memStrobe_b,
  output logic             memStrobeOe,
  output logic             busHoldAck_b,
  output logic             busHoldAckOe,
  output logic             irqAck_b,
  output logic             irqAckOe
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronization
  dsc_sync_if syncIf ();
  logic [8:0] syncVec;  // Packed synchronized pins

  // Pin synchronizers
  // two-flop synchronizers
  dsc_sync #(.WIDTH(9)) uSync (
    .clk       (clk),
    .rst_b     (rst_b),
    .pinsAsync ({romMapStrap, offCtrl_b, holdReq_b, branchCondIn_b, nmiIn_b, userIrqIn_b}),
    .pinsSync  (syncVec)
  );

  assign syncIf.userIrq    = syncVec[3:0];
  assign syncIf.nmi        = syncVec[4];
  assign syncIf.branchCond = syncVec[5];
  assign syncIf.hold       = syncVec[6];
  assign syncIf.off        = syncVec[7];
  assign syncIf.strap      = syncVec[8];

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]  irqPrev_r;     // Previous user interrupt levels
  logic        nmiPrev_r;     // Previous NMI level
  logic [3:0]  irqFlag_r;     // Pending user interrupt flags
  logic [3:0]  irqMask_r;     // Mask register
  logic        gim_r;         // Global mode, 1 blocks maskables
  logic        nmiPend_r;     // NMI pending
  logic        flag_r;        // Latched external flag value
  logic [1:0]  strapCnt_r;    // Edges since reset release, stops at 3
  dsc_state_e  state_r;       // Bus sequencer
  logic [1:0]  ackCnt_r;      // Cycles left in current access
  logic [15:0] vecAddr_r;     // Vector or access address being presented
  logic [3:0]  servBit_r;     // User flag serviced by current vector
  logic [3:0]  irqEdge;       // Falling edges on user interrupts
  logic        nmiEdge;       // Falling edge on NMI
  logic [3:0]  irqEnabled;    // Pending and unmasked
  logic [3:0]  irqWin;        // Highest-priority enabled request
  logic [3:0]  flagClr;       // Software clear pattern
  logic        wrCtrl;        // Control register write
  logic        offNow;        // Off control asserted

  assign irqEdge    = irqPrev_r & ~syncIf.userIrq;
  assign nmiEdge    = nmiPrev_r & ~syncIf.nmi;
  assign irqEnabled = irqFlag_r & irqMask_r & {4{~gim_r}};
  assign irqWin     = irqEnabled & (~irqEnabled + 4'h1);
  assign wrCtrl     = regWr && (regAddr == REG_CTRL);
  assign flagClr    = (regWr && (regAddr == REG_IRQ_FLAG)) ? regWrData[3:0] : 4'h0;
  assign offNow     = ~syncIf.off;

  ////////////////////////////////////////////////////////////////////
  // Edge detection history
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqPrev_r <= 4'hF;
      nmiPrev_r <= 1'b1;
    end else begin
      irqPrev_r <= syncIf.userIrq;
      nmiPrev_r <= syncIf.nmi;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pending flags; a new edge beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqFlag_r <= 4'h0;
    end else begin
      // set wins over clear or service
      irqFlag_r <= (irqFlag_r & ~flagClr & ~servBit_r) | irqEdge;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // NMI pending, independent of mask and mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmiPend_r <= 1'b0;
    end else if (nmiEdge) begin
      nmiPend_r <= 1'b1;
    end else if (state_r == ST_IDLE && syncIf.hold) begin
      // A hold grant must not drop a pending trap
      nmiPend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mask and mode registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqMask_r <= MASK_RST;
      gim_r     <= GIM_RST;
    end else begin
      if (regWr && (regAddr == REG_IRQ_MASK)) begin
        irqMask_r <= regWrData[3:0];
      end
      if (wrCtrl) begin
        gim_r <= regWrData[CTRL_GIM_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // External flag latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_r <= 1'b1;
    end else if (wrCtrl) begin
      if (regWrData[CTRL_XSET_BIT]) begin
        flag_r <= 1'b1;
      end else if (regWrData[CTRL_XCLR_BIT]) begin
        flag_r <= 1'b0;
      end else if (regWrData[CTRL_ST1_BIT]) begin
        flag_r <= regWrData[CTRL_ST1V_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode strap, caught once the synchronizer carries the real pin
  // The synchronizer leaves reset at its idle level, so the first two
  // edges after release would still show that level, not the strap
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strapCnt_r   <= 2'd0;
      computerMode <= 1'b0;
    end else if (strapCnt_r != 2'd3) begin
      strapCnt_r <= strapCnt_r + 2'd1;
      if (strapCnt_r == 2'd2) begin
        computerMode <= ~syncIf.strap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Branch input sampling; decode phase for cond-execute
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      branchTaken <= 1'b0;
      xcCondTrue  <= 1'b0;
    end else begin
      branchTaken <= branchExec & ~syncIf.branchCond;
      if (xcDecode) begin
        xcCondTrue <= ~syncIf.branchCond;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus sequencer; vector fetch, accesses and hold
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r   <= ST_RESET;
      ackCnt_r  <= 2'd0;
      vecAddr_r <= RESET_VEC;
      servBit_r <= 4'h0;
    end else begin
      servBit_r <= 4'h0;
      case (state_r)
        ST_RESET: begin
          state_r   <= ST_VEC;
          vecAddr_r <= RESET_VEC;
          ackCnt_r  <= 2'(ACK_CYCLES - 1);
        end
        ST_IDLE: begin
          if (!syncIf.hold) begin
            state_r <= ST_HOLD;
          end else if (nmiPend_r) begin
            state_r   <= ST_VEC;
            vecAddr_r <= NMI_VEC;
            ackCnt_r  <= 2'(ACK_CYCLES - 1);
          end else if (irqWin != 4'h0) begin
            state_r   <= ST_VEC;
            servBit_r <= irqWin;
            vecAddr_r <= USER_VEC_BASE + USER_VEC_STEP * {12'h000, irqWin};
            ackCnt_r  <= 2'(ACK_CYCLES - 1);
          end else if (accReq) begin
            state_r   <= ST_ACC;
            vecAddr_r <= accAddr;
            ackCnt_r  <= 2'(ACK_CYCLES - 1);
          end
        end
        ST_ACC, ST_VEC: begin
          if (ackCnt_r == 2'd0) begin
            state_r <= ST_IDLE;
          end else begin
            ackCnt_r <= ackCnt_r - 2'd1;
          end
        end
        ST_HOLD: begin
          if (syncIf.hold) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered from current-state terms
  dsc_space_e  accSpace_r;  // Space of current access
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accSpace_r <= SPACE_PROG;
    end else if (state_r == ST_IDLE && accReq) begin
      accSpace_r <= accSpace;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addrOut        <= 16'h0000;
      addrOe         <= 1'b0;
      dataSpaceSel_b <= 1'b1;
      progSpaceSel_b <= 1'b1;
      ioSpaceSel_b   <= 1'b1;
      spaceSelOe     <= 1'b1;
      memStrobe_b    <= 1'b1;
      memStrobeOe    <= 1'b1;
      busHoldAck_b   <= 1'b1;
      busHoldAckOe   <= 1'b1;
      irqAck_b       <= 1'b1;
      irqAckOe       <= 1'b1;
      extFlagOut     <= 1'b1;
      extFlagOe      <= 1'b1;
      fetchAddr      <= RESET_VEC;
      fetchValid     <= 1'b0;
      coreHalted     <= 1'b1;
    end else begin
      addrOut        <= vecAddr_r;
      addrOe         <= (state_r != ST_HOLD) && !offNow;
      progSpaceSel_b <= !((state_r == ST_VEC) ||
                          (state_r == ST_ACC && accSpace_r == SPACE_PROG));
      dataSpaceSel_b <= !(state_r == ST_ACC && accSpace_r == SPACE_DATA);
      ioSpaceSel_b   <= !(state_r == ST_ACC && accSpace_r == SPACE_IO);
      // float selects in hold or off
      spaceSelOe     <= (state_r != ST_HOLD) && !offNow;
      memStrobe_b    <= !((state_r == ST_VEC) ||
                          (state_r == ST_ACC && accSpace_r != SPACE_IO));
      // float strobe in hold or off
      memStrobeOe    <= (state_r != ST_HOLD) && !offNow;
      busHoldAck_b   <= !(state_r == ST_HOLD);
      busHoldAckOe   <= !offNow;
      irqAck_b       <= !(state_r == ST_VEC && vecAddr_r != RESET_VEC);
      irqAckOe       <= !offNow;
      extFlagOut     <= flag_r;
      extFlagOe      <= !offNow;
      fetchAddr      <= vecAddr_r;
      fetchValid     <= (state_r == ST_VEC) && (ackCnt_r == 2'd0);
      coreHalted     <= (state_r == ST_RESET) || (state_r == ST_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      if (regAddr == REG_IRQ_FLAG) begin
        regRdData <= {28'h000_0000, irqFlag_r};
      end else if (regAddr == REG_IRQ_MASK) begin
        regRdData <= {28'h000_0000, irqMask_r};
      end else if (regAddr == REG_CTRL) begin
        regRdData <= {27'h000_0000, flag_r, 3'b000, gim_r};
      end else if (regAddr == REG_STATUS) begin
        regRdData <= {24'h00_0000, computerMode, nmiPend_r, syncIf.branchCond,
                      2'b00, state_r};
      end else if (regAddr == REG_VECTOR) begin
        regRdData <= {16'h0000, vecAddr_r};
      end else begin
        regRdData <= 32'h0000_0000;
      end
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule

/* File: pkg/dsc_pkg.sv */
// Package of constants and types for the DSP system control pin block
// Functional notes
// - Four user interrupts prioritized, masked by mask/mode
// - Software polls and clears interrupt flags
// - Non-maskable interrupt never blocked
// - NMI diverts flow to its vector
// - Reset stops execution, reinitializes state
// - After reset, fetch starts at 0FF80h
// - Mode strap sampled at reset; low maps ROM
// - Branch taken only when branch input active
// - Cond-execute samples branch input at decode
// - Flag output latched; set, clear, status load
// - Flag high in reset, floats when off low
// - Space selects high except during external access
// - Space select low only with valid address
// - Space selects float in hold or off
// - Memory strobe low only for data/program access
// - Memory strobe floats in hold or off
// - Hold request granted, then lines float
// - Hold ack when floated; high during reset
// - Interrupt ack marks vector fetch
package dsc_pkg;

  // Register indices on the plain register port
  localparam logic [3:0]  REG_IRQ_FLAG   = 4'h0;  // Pending flags, write one to clear
  localparam logic [3:0]  REG_IRQ_MASK   = 4'h1;  // Per-source enable
  localparam logic [3:0]  REG_CTRL       = 4'h2;  // Mode bit and flag-output control
  localparam logic [3:0]  REG_STATUS     = 4'h3;  // Live block state
  localparam logic [3:0]  REG_VECTOR     = 4'h4;  // Last vector or access address presented

  // Control register field positions
  localparam int          CTRL_GIM_BIT   = 0;     // Global interrupt mode, 1 blocks maskables
  localparam int          CTRL_XSET_BIT  = 1;     // Set-status-bit action on the flag output
  localparam int          CTRL_XCLR_BIT  = 2;     // Clear-status-bit action on the flag output
  localparam int          CTRL_ST1_BIT   = 3;     // Status-one load action
  localparam int          CTRL_ST1V_BIT  = 4;     // Flag value carried by the status-one load

  // Reset values
  localparam logic [3:0]  MASK_RST       = 4'h0;
  localparam logic        GIM_RST        = 1'b1;  // Maskables blocked after reset

  // Vectors
  localparam logic [15:0] RESET_VEC      = 16'hFF80;
  localparam logic [15:0] NMI_VEC        = 16'hFF88;
  localparam logic [15:0] USER_VEC_BASE  = 16'hFFC0;
  localparam logic [15:0] USER_VEC_STEP  = 16'h0004;

  // Bus cycle timing, clock cycles
  localparam int          ACK_CYCLES     = 2;

  // Space selection encoding
  typedef enum logic [1:0] {
    SPACE_PROG = 2'b00,
    SPACE_DATA = 2'b01,
    SPACE_IO   = 2'b10
  } dsc_space_e;

  // External bus sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE  = 3'b001,
    ST_ACC   = 3'b010,
    ST_VEC   = 3'b011,
    ST_HOLD  = 3'b100
  } dsc_state_e;

endpackage

/* File: pkg/dsc_sync_if.sv */
// Interface carrying synchronized pin levels to the core
`timescale 1ns/10ps
interface dsc_sync_if;
  logic [3:0] userIrq;     // Synchronized user interrupts, active low
  logic       nmi;         // Synchronized non-maskable interrupt, active low
  logic       branchCond;  // Synchronized branch input, active low
  logic       hold;        // Synchronized hold request, active low
  logic       off;         // Synchronized off control, active low
  logic       strap;       // Synchronized mode strap

  modport src (output userIrq, output nmi, output branchCond, output hold,
               output off, output strap);
  modport dst (input userIrq, input nmi, input branchCond, input hold,
               input off, input strap);
endinterface

/* File: sim/dsc_asserts.sv */
// Concurrent checks on the pins of the system control block
`timescale 1ns/10ps
module dsc_asserts
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Inputs that cause pin activity
  input wire logic        offCtrl_b,
  input wire logic        holdReq_b,
  input wire logic        branchExec,
  // Pins and results
  input wire logic [15:0] addrOut,
  input wire logic        addrOe,
  input wire logic        extFlagOut,
  input wire logic        dataSpaceSel_b,
  input wire logic        progSpaceSel_b,
  input wire logic        ioSpaceSel_b,
  input wire logic        spaceSelOe,
  input wire logic        memStrobe_b,
  input wire logic        memStrobeOe,
  input wire logic        busHoldAck_b,
  input wire logic        irqAck_b,
  input wire logic        irqAckOe,
  input wire logic        coreHalted,
  input wire logic        branchTaken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Off must be seen through the synchronizer before outputs float
  sequence offHeld;
    !offCtrl_b [*3];
  endsequence
  // Hold may wait for a running bus cycle to finish first
  sequence holdHeld;
    !holdReq_b [*8];
  endsequence
  reset_state_a: assert property ($rose(rst_b) |-> extFlagOut && busHoldAck_b && coreHalted)
    else $error("reset state wrong");
  reset_vector_a: assert property ($rose(rst_b) |-> ##[1:4] (!progSpaceSel_b && addrOut == RESET_VEC))
    else $error("no fetch at reset vector");
  one_space_a: assert property (spaceSelOe |-> $onehot0(~{dataSpaceSel_b, progSpaceSel_b, ioSpaceSel_b}))
    else $error("two spaces selected");
  strobe_space_a: assert property (memStrobeOe && !memStrobe_b |-> ioSpaceSel_b)
    else $error("strobe during io access");
  sel_addr_a: assert property (!(dataSpaceSel_b && progSpaceSel_b && ioSpaceSel_b) |-> addrOe)
    else $error("select without address");
  off_float_a: assert property (offHeld |=> !spaceSelOe && !memStrobeOe && !irqAckOe)
    else $error("outputs driven while off");
  hold_grant_a: assert property (holdHeld |=> !busHoldAck_b && !spaceSelOe && !memStrobeOe)
    else $error("hold not granted");
  ack_vector_a: assert property (irqAckOe && !irqAck_b |-> addrOe && addrOut >= RESET_VEC)
    else $error("ack outside vector fetch");
  branch_cause_a: assert property (branchTaken |-> $past(branchExec))
    else $error("branch without instruction");
endmodule

/* File: sim/dsc_far_side.sv */
// Interrupt sources and bus-hold requester facing the block
`timescale 1ns/10ps
module dsc_far_side (
  // Clock
  input wire logic  clk,
  // Commands from the bench
  input wire logic [3:0] irqCmd,
  input wire logic  nmiCmd,
  input wire logic  holdCmd,
  // Pins toward the block
  output logic [3:0] userIrqIn_b,
  output logic  nmiIn_b,
  output logic  holdReq_b
);
  logic [4:0] req;                       // Event requests, nmi on top
  logic [2:0] cnt [5] = '{default: 3'h0};  // Low time left per line
  assign req = {nmiCmd, irqCmd};
  // Lines stay low four cycles, long enough to cross the synchronizer
  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (req[i]) cnt[i] <= 3'h4;
      else if (cnt[i] != 3'h0) cnt[i] <= cnt[i] - 3'h1;
    end
  end
  // Released lines return to their pull-up level
  always_comb begin
    for (int i = 0; i < 4; i++) userIrqIn_b[i] = (cnt[i] == 3'h0);
  end
  assign nmiIn_b = (cnt[4] == 3'h0);
  assign holdReq_b = !holdCmd;
endmodule

/* File: sim/dsc_sys_ctrl_tb.sv */
// Self-checking bench for the system control pin block
`timescale 1ns/10ps
module dsc_sys_ctrl_tb;
  import dsc_pkg::*;
  logic clk = 0, rst_b = 0, nmiIn_b, holdReq_b, branchCondIn_b = 1, offCtrl_b = 1;
  logic romMapStrap = 0, accReq = 0, xcDecode = 0, branchExec = 0, regWr = 0, regRd = 0;
  logic [3:0] userIrqIn_b, regAddr = 4'h0, irqCmd = 4'h0;
  logic nmiCmd = 0, holdCmd = 0, anySel;
  dsc_space_e accSpace = SPACE_PROG;
  logic [15:0] accAddr = 16'h0000, fetchAddr, addrOut, seed = 16'hF800, a1, a2;
  logic [31:0] regWrData = 32'h0000_0000, regRdData, d;
  logic fetchValid, computerMode, branchTaken, xcCondTrue, coreHalted, addrOe, extFlagOut;
  logic extFlagOe, dataSpaceSel_b, progSpaceSel_b, ioSpaceSel_b, spaceSelOe, memStrobe_b;
  logic memStrobeOe, busHoldAck_b, busHoldAckOe, irqAck_b, irqAckOe;
  logic [4:0] fw [4] = '{5'h05, 5'h03, 5'h09, 5'h19};  // Clear, set, load 0, load 1
  int n_fail = 0, tests_run = 0, ackCnt = 0, k0;
  int expFlag;
  always #25 clk = ~clk;
  always_comb anySel = dataSpaceSel_b & progSpaceSel_b & ioSpaceSel_b;
  always @(negedge irqAck_b) ackCnt++;
  dsc_sys_ctrl dut_u (.clk, .rst_b, .userIrqIn_b, .nmiIn_b, .branchCondIn_b, .holdReq_b,
    .offCtrl_b, .romMapStrap, .accReq, .accSpace, .accAddr, .xcDecode, .branchExec, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .fetchAddr, .fetchValid, .computerMode,
    .branchTaken, .xcCondTrue, .coreHalted, .addrOut, .addrOe, .extFlagOut, .extFlagOe,
    .dataSpaceSel_b, .progSpaceSel_b, .ioSpaceSel_b, .spaceSelOe, .memStrobe_b, .memStrobeOe,
    .busHoldAck_b, .busHoldAckOe, .irqAck_b, .irqAckOe);
  dsc_far_side far_u (.clk, .irqCmd, .nmiCmd, .holdCmd, .userIrqIn_b, .nmiIn_b, .holdReq_b);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Advance n edges and step past them so updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait; a hang counts as a failure and ends the run
  task automatic wait_lvl(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 40) begin
      tick(1);
      k++;
    end
    if (s !== v) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1 v = regRdData;
  endtask
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(19);
    chk({extFlagOut, busHoldAck_b, coreHalted, regRdData[0]}, 4'hE);
    @(posedge clk);
    rst_b <= 1;
    tick(8);
    chk(computerMode, 1);
    rd(REG_CTRL, d);
    chk(d, 32'h0000_0011);
    rd(4'hF, d);
    chk(d, 0);
    // Flag output actions, gim left set
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, 32'(fw[i]));
      tick(2);
      chk(extFlagOut, i % 2);
    end
    // Masked by the mode bit: flag pends, no service
    k0 = ackCnt;
    wr(REG_IRQ_MASK, 32'h0000_000F);
    @(posedge clk) irqCmd <= 4'h4;
    @(posedge clk) irqCmd <= 4'h0;
    tick(8);
    expFlag = 4;
    rd(REG_IRQ_FLAG, d);
    chk(d, expFlag);
    wr(REG_IRQ_FLAG, 32'h0000_0004);
    rd(REG_IRQ_FLAG, d);
    chk(d, 0);
    // Masked per source, then both released at once
    wr(REG_IRQ_MASK, 0);
    wr(REG_CTRL, 0);
    @(posedge clk) irqCmd <= 4'hA;
    @(posedge clk) irqCmd <= 4'h0;
    tick(8);
    rd(REG_IRQ_FLAG, d);
    chk(d, 32'h0000_000A);
    chk(ackCnt, k0);
    wr(REG_IRQ_MASK, 32'h0000_000F);
    wait_lvl(irqAck_b, 0);
    a1 = addrOut;
    wait_lvl(irqAck_b, 1);
    wait_lvl(irqAck_b, 0);
    a2 = addrOut;
    chk(a1 < a2 && a1 >= USER_VEC_BASE, 1);
    tick(4);
    rd(REG_IRQ_FLAG, d);
    chk(d, 0);
    // NMI with everything blocked
    wr(REG_CTRL, 1);
    wr(REG_IRQ_MASK, 0);
    @(posedge clk) nmiCmd <= 1;
    @(posedge clk) nmiCmd <= 0;
    wait_lvl(irqAck_b, 0);
    chk(addrOut, NMI_VEC);
    tick(1);
    chk({fetchValid, fetchAddr}, {1'b1, NMI_VEC});
    tick(5);
    // One access per space at a random address
    for (int s = 0; s < 3; s++) begin
      a1 = xs();
      @(posedge clk);
      accReq <= 1;
      accSpace <= dsc_space_e'(s);
      accAddr <= a1;
      @(posedge clk) accReq <= 0;
      wait_lvl(anySel, 0);
      chk({ioSpaceSel_b, dataSpaceSel_b, progSpaceSel_b}, ~(3'h1 << s) & 3'h7);
      chk(addrOut, a1);
      tick(1);
      chk(memStrobe_b, s == 2);
      wait_lvl(anySel, 1);
    end
    // Hold grant floats the bus
    @(posedge clk) holdCmd <= 1;
    wait_lvl(busHoldAck_b, 0);
    chk({spaceSelOe, memStrobeOe, addrOe, coreHalted}, 1);
    // Keep the request up long enough for the grant check to see it
    tick(6);
    @(posedge clk) holdCmd <= 0;
    tick(6);
    // Off floats every output
    @(posedge clk) offCtrl_b <= 0;
    tick(5);
    chk({extFlagOe, spaceSelOe, memStrobeOe, irqAckOe, busHoldAckOe}, 0);
    @(posedge clk) offCtrl_b <= 1;
    // Branch and conditional execute, pin active then idle
    for (int v = 0; v < 2; v++) begin
      @(posedge clk) branchCondIn_b <= v[0];
      tick(4);
      @(posedge clk);
      branchExec <= 1;
      xcDecode <= 1;
      @(posedge clk);
      branchExec <= 0;
      xcDecode <= 0;
      #1 chk({branchTaken, xcCondTrue}, v ? 0 : 3);
    end
    // Drive the flag low first so reset has something to restore
    wr(REG_CTRL, 32'h0000_0005);
    tick(2);
    chk(extFlagOut, 0);
    // Second reset with the strap high
    @(posedge clk);
    romMapStrap <= 1;
    rst_b <= 0;
    tick(3);
    chk(extFlagOut, 1);
    @(posedge clk) rst_b <= 1;
    tick(8);
    chk(computerMode, 0);
    complete_run();
  end
endmodule
bind dsc_sys_ctrl dsc_asserts chk_u (.clk, .rst_b, .offCtrl_b, .holdReq_b, .branchExec,
  .addrOut, .addrOe, .extFlagOut, .dataSpaceSel_b, .progSpaceSel_b, .ioSpaceSel_b,
  .spaceSelOe, .memStrobe_b, .memStrobeOe, .busHoldAck_b, .irqAck_b, .irqAckOe,
  .coreHalted, .branchTaken);
